// ### pkg/apm_pkg.sv
/*
 * Shared constants and carrier types for the auto powerdown manager.
 * Assumes a 40 MHz core clock and an 8-bit host data path.
 */
`default_nettype none
package apm_pkg;
    // floppy register offsets from the controller base
    localparam logic [2:0] OFS_STATUS_A = 3'h0;
    localparam logic [2:0] OFS_STATUS_B = 3'h1;
    localparam logic [2:0] OFS_DRIVE_OUT = 3'h2;
    localparam logic [2:0] OFS_RATE_MAIN = 3'h4;
    localparam logic [2:0] OFS_DATA = 3'h5;
    localparam logic [2:0] OFS_INPUT_CFG = 3'h7;
    // field layout
    localparam logic [7:0] DRIVE_OUT_MOTOR_MASK = 8'hF0;
    localparam int DRIVE_OUT_RESET_N_BIT = 2;
    localparam int RATE_RESET_BIT = 7;
    localparam int RATE_PD_BIT = 6;
    localparam logic [7:0] MAIN_STATUS_IDLE = 8'h80;
    localparam logic [7:0] DRIVE_OUT_RESET_VAL = 8'h00;
    localparam logic [7:0] RATE_RESET_VAL = 8'h00;
    localparam logic [7:0] CONFIG_RESET_VAL = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // extended control mode field
    localparam logic [2:0] ECR_SPP = 3'h0;
    localparam logic [2:0] ECR_BIDIR = 3'h1;
    localparam logic [2:0] ECR_EPP = 3'h4;
    // auto powerdown timer
    localparam int AUTO_PD_TIME_US = 10000;
    localparam int CLK_FREQ_MHZ = 40;
    localparam int AUTO_PD_CYCLES = AUTO_PD_TIME_US * CLK_FREQ_MHZ;
    localparam int NUM_SERIAL = 2;

    typedef enum logic [2:0] {
        FDC_RUN = 3'b001,
        FDC_AUTO_PD = 3'b010,
        FDC_RATE_PD = 3'b100
    } apm_fdc_state_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } apm_host_req_type;

    typedef struct packed {
        logic [7:0] status_a;
        logic [7:0] status_b;
        logic [7:0] main_status;
        logic [7:0] input_status;
        logic [7:0] data_out;
        logic int_pending;
        logic head_unload_done;
    } apm_fdc_status_type;

    typedef struct packed {
        logic motor0_on_n;
        logic drive0_select_n;
        logic write_stream_n;
        logic write_gate_n;
        logic head_direction_n;
        logic head_step_n;
        logic head_select_n;
        logic [1:0] density_sel;
    } apm_drive_core_type;

    typedef struct packed {
        logic value;
        logic oe_n;
    } apm_pin_type;
endpackage : apm_pkg
`default_nettype wire

// ### verilog/apm_manager.sv
/*
 * Auto powerdown manager: host decode gating, PLL power select, floppy
 * auto/rate powerdown with register wake, serial and parallel auto powerdown,
 * wake-event output. Assumes the floppy, serial and parallel cores sit beside
 * it and supply their status; the wake logic sits on the trickle supply.
 */
`default_nettype none
// What this block does
// - ignore and decode no host access while supply-good is low
// - wake inputs and wake-event output keep working while supply-good is low
// - PLL off when its bit is set; powered only with bits 0 and supply good
// - status, drive-output, input reads and rate/config writes do not wake
// - main status read or any data register access wakes the floppy
// - writes in powerdown are kept; reads return live status
// - motor-enable or software-reset writes wake; other such writes do not
// - after a non-waking access the floppy drops back to low power itself
// - host pins keep working; interrupt and DMA requests held low
// - motor0, select0, write data and gate tristate; others stay active
// - serial auto powerdown only when its enable bit is set
// - transmitter sleeps once holding buffer and shift register are empty
// - receiver sleeps when its FIFO is empty and it awaits a start bit
// - a transmit buffer write wakes the transmitter
// - any change on the receive input wakes the receiver
// - ring indicator keeps following its input during powerdown
// - parallel auto powerdown only when its enable bit is set
// - EPP sleeps if not enabled, or ECP mode without EPP selected
// - ECP sleeps if not enabled, or SPP, bidirectional or EPP selected
// - parallel power state follows mode changes at once
// - floppy auto-sleeps only with motors off, idle, head unloaded, timer done
// - after wake the floppy restarts its timer and sleeps again later
// - rate-register powerdown overrides auto; after wake auto applies again
module apm_manager
    import apm_pkg::*;
#(
    parameter int unsigned AUTO_PD_COUNT = apm_pkg::AUTO_PD_CYCLES,
    parameter int unsigned SERIAL_PORTS = apm_pkg::NUM_SERIAL
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic supply_good_internal,
    input wire apm_pkg::apm_host_req_type host_req,
    output logic [7:0] host_rdata,
    output logic host_ack,
    output logic fifo_read_strobe,
    output logic fifo_write_strobe,
    input wire apm_pkg::apm_fdc_status_type fdc_status,
    input wire apm_pkg::apm_drive_core_type drive_core,
    input wire logic core_interrupt_request,
    input wire logic core_dma_request,
    output logic [7:0] drive_output_control,
    output logic [7:0] rate_select,
    output logic [7:0] rate_config_control,
    output logic fdc_powered_down,
    output logic fdc_access_awake,
    output logic fdc_wake,
    output apm_pkg::apm_pin_type motor0_on_n,
    output apm_pkg::apm_pin_type drive0_select_n,
    output apm_pkg::apm_pin_type write_stream_n,
    output apm_pkg::apm_pin_type write_gate_n,
    output logic head_direction_n,
    output logic head_step_n,
    output logic head_select_n,
    output logic [1:0] density_sel,
    output logic interrupt_request_out,
    output logic dma_request_out,
    input wire logic pll_powerdown_bit,
    input wire logic event_power_bit,
    output logic pll_powered,
    output logic pll_reserved,
    input wire logic floppy_auto_pd_enable,
    input wire logic parport_auto_pd_enable,
    input wire logic serial1_auto_pd_enable,
    input wire logic serial2_auto_pd_enable,
    input wire logic epp_config_enable,
    input wire logic ecp_config_enable,
    input wire logic [2:0] ecr_mode,
    output logic epp_powered_down,
    output logic ecp_powered_down,
    input wire logic [SERIAL_PORTS-1:0] holding_empty,
    input wire logic [SERIAL_PORTS-1:0] shift_empty,
    input wire logic [SERIAL_PORTS-1:0] transmit_holding_write,
    input wire logic [SERIAL_PORTS-1:0] rx_fifo_empty,
    input wire logic [SERIAL_PORTS-1:0] rx_wait_start,
    input wire logic [SERIAL_PORTS-1:0] serial_receive_in,
    input wire logic [SERIAL_PORTS-1:0] ring_indicator,
    output logic [SERIAL_PORTS-1:0] tx_powered_down,
    output logic [SERIAL_PORTS-1:0] rx_powered_down,
    output logic [SERIAL_PORTS-1:0] ring_indicator_level,
    output logic wake_event_out_n
);
    import apm_pkg::*;

    localparam int TW = $clog2(AUTO_PD_COUNT + 1);

    if (AUTO_PD_COUNT < 1 || SERIAL_PORTS != NUM_SERIAL) begin : g_param_check
        $error("apm_manager: unsupported parameter values");
    end

    logic [1:0] reset_pipe;
    logic rst_n;
    logic sg_meta;
    logic sg_sync;
    logic [SERIAL_PORTS-1:0] rx_meta;
    logic [SERIAL_PORTS-1:0] rx_sync;
    logic [SERIAL_PORTS-1:0] rx_prev;
    logic [SERIAL_PORTS-1:0] ri_meta;
    logic [SERIAL_PORTS-1:0] ri_sync;
    logic [SERIAL_PORTS-1:0] ri_prev;
    logic [SERIAL_PORTS-1:0] rx_edge;
    logic [SERIAL_PORTS-1:0] ri_edge;
    logic [SERIAL_PORTS-1:0] serial_enable;
    logic rd_ok;
    logic wr_ok;
    logic wake_access;
    logic rate_pd_write;
    logic auto_ready;
    logic [TW-1:0] pd_timer;
    logic wake_latched;
    apm_fdc_state_type state;
    apm_fdc_state_type next_state;

    // reset release through two flip-flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reset_pipe <= 2'b00;
        end else begin
            reset_pipe <= {reset_pipe[0], 1'b1};
        end
    end
    assign rst_n = reset_pipe[1];

    // synchronisers for the asynchronous supply and wake inputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sg_meta <= 1'b0;
            sg_sync <= 1'b0;
            rx_meta <= '1;
            rx_sync <= '1;
            rx_prev <= '1;
            ri_meta <= '0;
            ri_sync <= '0;
            ri_prev <= '0;
        end else begin
            sg_meta <= supply_good_internal;
            sg_sync <= sg_meta;
            rx_meta <= serial_receive_in;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
            ri_meta <= ring_indicator;
            ri_sync <= ri_meta;
            ri_prev <= ri_sync;
        end
    end
    assign rx_edge = rx_sync ^ rx_prev;
    assign ri_edge = ri_sync ^ ri_prev;

    // host decode, gated by supply good
    assign rd_ok = sg_sync && host_req.rd;
    assign wr_ok = sg_sync && host_req.wr;
    assign fifo_read_strobe = rd_ok && host_req.addr == OFS_DATA;
    assign fifo_write_strobe = wr_ok && host_req.addr == OFS_DATA;

    // accesses that wake the floppy; all others leave it asleep
    always_comb begin
        wake_access = 1'b0;
        if (rd_ok && host_req.addr == OFS_RATE_MAIN) begin
            wake_access = 1'b1;
        end
        if (fifo_read_strobe || fifo_write_strobe) begin
            wake_access = 1'b1;
        end
        if (wr_ok && host_req.addr == OFS_DRIVE_OUT &&
            ((host_req.wdata & DRIVE_OUT_MOTOR_MASK) != READ_ZERO ||
             !host_req.wdata[DRIVE_OUT_RESET_N_BIT])) begin
            wake_access = 1'b1;
        end
        if (wr_ok && host_req.addr == OFS_RATE_MAIN && host_req.wdata[RATE_RESET_BIT]) begin
            wake_access = 1'b1;
        end
    end
    assign rate_pd_write = wr_ok && host_req.addr == OFS_RATE_MAIN &&
        host_req.wdata[RATE_PD_BIT] && !wake_access;

    // read data and ack one cycle after the request, awake or not
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            host_rdata <= READ_ZERO;
            host_ack <= 1'b0;
        end else begin
            host_ack <= rd_ok || wr_ok;
            if (rd_ok) begin
                case (host_req.addr)
                    OFS_STATUS_A: host_rdata <= fdc_status.status_a;
                    OFS_STATUS_B: host_rdata <= fdc_status.status_b;
                    OFS_DRIVE_OUT: host_rdata <= drive_output_control;
                    OFS_RATE_MAIN: host_rdata <= fdc_status.main_status;
                    OFS_DATA: host_rdata <= fdc_status.data_out;
                    OFS_INPUT_CFG: host_rdata <= fdc_status.input_status;
                    default: host_rdata <= READ_ZERO;
                endcase
            end
        end
    end

    // write-only and shadowed registers, retained through powerdown
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_output_control <= DRIVE_OUT_RESET_VAL;
            rate_select <= RATE_RESET_VAL;
            rate_config_control <= CONFIG_RESET_VAL;
        end else begin
            if (wr_ok && host_req.addr == OFS_DRIVE_OUT) begin
                drive_output_control <= host_req.wdata;
            end
            if (wr_ok && host_req.addr == OFS_RATE_MAIN) begin
                rate_select <= host_req.wdata;
            end else if (state == FDC_RATE_PD && wake_access) begin
                rate_select[RATE_PD_BIT] <= 1'b0;
            end
            if (wr_ok && host_req.addr == OFS_INPUT_CFG) begin
                rate_config_control <= host_req.wdata;
            end
        end
    end

    // auto powerdown timer: cancelled when disabled, restarted on every wake
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_timer <= TW'(AUTO_PD_COUNT);
        end else if (state != FDC_RUN || !floppy_auto_pd_enable || wake_access) begin
            pd_timer <= TW'(AUTO_PD_COUNT);
        end else if (pd_timer != '0) begin
            pd_timer <= pd_timer - TW'(1);
        end
    end

    assign auto_ready = floppy_auto_pd_enable &&
        (drive_output_control & DRIVE_OUT_MOTOR_MASK) == READ_ZERO &&
        fdc_status.main_status == MAIN_STATUS_IDLE && !fdc_status.int_pending &&
        fdc_status.head_unload_done && pd_timer == '0;

    always_comb begin
        next_state = state;
        case (state)
            FDC_RUN: begin
                if (rate_pd_write) begin
                    next_state = FDC_RATE_PD;
                end else if (auto_ready && !wake_access) begin
                    next_state = FDC_AUTO_PD;
                end
            end
            FDC_AUTO_PD: begin
                if (wake_access || !floppy_auto_pd_enable) begin
                    next_state = FDC_RUN;
                end else if (rate_pd_write) begin
                    next_state = FDC_RATE_PD;
                end
            end
            FDC_RATE_PD: begin
                if (wake_access) begin
                    next_state = FDC_RUN;
                end
            end
            default: next_state = FDC_RUN;
        endcase
    end

    // non-waking accesses leave the state alone, so no wake-up is needed after
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= FDC_RUN;
        end else begin
            state <= next_state;
        end
    end

    assign fdc_powered_down = state != FDC_RUN;
    assign fdc_wake = fdc_powered_down && wake_access;
    // core clocks run while awake, and while asleep only during an access on the bus
    assign fdc_access_awake = !fdc_powered_down || rd_ok || wr_ok;
    // requests held low while asleep; host data pins untouched
    assign interrupt_request_out = core_interrupt_request && !fdc_powered_down;
    assign dma_request_out = core_dma_request && !fdc_powered_down;

    // drive pins: four tristate in powerdown, the rest stay active
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            motor0_on_n <= '{value: 1'b1, oe_n: 1'b1};
            drive0_select_n <= '{value: 1'b1, oe_n: 1'b1};
            write_stream_n <= '{value: 1'b1, oe_n: 1'b1};
            write_gate_n <= '{value: 1'b1, oe_n: 1'b1};
            head_direction_n <= 1'b1;
            head_step_n <= 1'b1;
            head_select_n <= 1'b1;
            density_sel <= 2'b00;
        end else begin
            motor0_on_n <= '{value: drive_core.motor0_on_n, oe_n: fdc_powered_down};
            drive0_select_n <= '{value: drive_core.drive0_select_n, oe_n: fdc_powered_down};
            write_stream_n <= '{value: drive_core.write_stream_n, oe_n: fdc_powered_down};
            write_gate_n <= '{value: drive_core.write_gate_n, oe_n: fdc_powered_down};
            head_direction_n <= drive_core.head_direction_n;
            head_step_n <= drive_core.head_step_n;
            head_select_n <= drive_core.head_select_n;
            density_sel <= drive_core.density_sel;
        end
    end

    // PLL power select
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_powered <= 1'b0;
            pll_reserved <= 1'b0;
        end else begin
            pll_powered <= !pll_powerdown_bit && !event_power_bit && sg_sync;
            pll_reserved <= !pll_powerdown_bit && (event_power_bit || !sg_sync);
        end
    end

    // parallel port power state, re-evaluated every cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            epp_powered_down <= 1'b0;
            ecp_powered_down <= 1'b0;
        end else begin
            epp_powered_down <= parport_auto_pd_enable && (!epp_config_enable ||
                (ecp_config_enable && ecr_mode != ECR_EPP));
            ecp_powered_down <= parport_auto_pd_enable && (!ecp_config_enable ||
                ecr_mode == ECR_SPP || ecr_mode == ECR_BIDIR ||
                ecr_mode == ECR_EPP);
        end
    end

    // wake event latches synced input edges only while supply good is low; cleared once it is high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_latched <= 1'b0;
        end else if (!sg_sync && (|rx_edge || |ri_edge)) begin
            wake_latched <= 1'b1;
        end else if (sg_sync) begin
            wake_latched <= 1'b0;
        end
    end
    assign wake_event_out_n = !wake_latched;

    assign serial_enable = {serial2_auto_pd_enable, serial1_auto_pd_enable};

    for (genvar i = 0; i < SERIAL_PORTS; i++) begin : g_serial
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                tx_powered_down[i] <= 1'b0;
                rx_powered_down[i] <= 1'b0;
                ring_indicator_level[i] <= 1'b0;
            end else begin
                ring_indicator_level[i] <= ri_sync[i];
                if (!serial_enable[i] || transmit_holding_write[i]) begin
                    tx_powered_down[i] <= 1'b0;
                end else if (holding_empty[i] && shift_empty[i]) begin
                    tx_powered_down[i] <= 1'b1;
                end
                if (!serial_enable[i] || rx_edge[i]) begin
                    rx_powered_down[i] <= 1'b0;
                end else if (rx_fifo_empty[i] && rx_wait_start[i]) begin
                    rx_powered_down[i] <= 1'b1;
                end
            end
        end

        property p_tx_wake;
            @(posedge clk) disable iff (!rst_n)
            transmit_holding_write[i] |=> !tx_powered_down[i];
        endproperty
        a_tx_wake: assert property (p_tx_wake) else $error("tx stayed asleep");

        property p_rx_wake;
            @(posedge clk) disable iff (!rst_n)
            $changed(rx_sync[i]) |=> !rx_powered_down[i];
        endproperty
        a_rx_wake: assert property (p_rx_wake) else $error("rx stayed asleep");

        property p_serial_off;
            @(posedge clk) disable iff (!rst_n)
            !serial_enable[i] |=> !tx_powered_down[i] && !rx_powered_down[i];
        endproperty
        a_serial_off: assert property (p_serial_off) else $error("serial pd w/o enable");
    end

    property p_no_decode;
        @(posedge clk) disable iff (!rst_n)
        !sg_sync |=> !host_ack;
    endproperty
    a_no_decode: assert property (p_no_decode) else $error("access decoded w/o supply");

    property p_pll;
        @(posedge clk) disable iff (!rst_n)
        pll_powerdown_bit |=> !pll_powered && !pll_reserved;
    endproperty
    a_pll: assert property (p_pll) else $error("pll not powered down");

    property p_status_no_wake;
        @(posedge clk) disable iff (!rst_n)
        state == FDC_AUTO_PD && floppy_auto_pd_enable && rd_ok && !wr_ok &&
            host_req.addr == OFS_STATUS_A |=> state == FDC_AUTO_PD;
    endproperty
    a_status_no_wake: assert property (p_status_no_wake) else $error("status read woke");

    property p_main_wake;
        @(posedge clk) disable iff (!rst_n)
        fdc_powered_down && rd_ok && host_req.addr == OFS_RATE_MAIN |=> state == FDC_RUN;
    endproperty
    a_main_wake: assert property (p_main_wake) else $error("main status read no wake");

    property p_motor_wake;
        @(posedge clk) disable iff (!rst_n)
        fdc_powered_down && wr_ok && host_req.addr == OFS_DRIVE_OUT &&
            (host_req.wdata & DRIVE_OUT_MOTOR_MASK) != READ_ZERO
            |=> state == FDC_RUN ##1 !fdc_powered_down;
    endproperty
    a_motor_wake: assert property (p_motor_wake) else $error("motor write no wake");

    property p_req_low;
        @(posedge clk) disable iff (!rst_n)
        fdc_powered_down |-> !interrupt_request_out && !dma_request_out;
    endproperty
    a_req_low: assert property (p_req_low) else $error("request high in powerdown");

    property p_tristate;
        @(posedge clk) disable iff (!rst_n)
        fdc_powered_down |=> motor0_on_n.oe_n && drive0_select_n.oe_n &&
            write_stream_n.oe_n && write_gate_n.oe_n;
    endproperty
    a_tristate: assert property (p_tristate) else $error("drive pin not tristated");

    property p_auto_entry;
        @(posedge clk) disable iff (!rst_n)
        state == FDC_RUN ##1 state == FDC_AUTO_PD |-> $past(pd_timer) == '0 &&
            $past(fdc_status.main_status) == MAIN_STATUS_IDLE;
    endproperty
    a_auto_entry: assert property (p_auto_entry) else $error("early auto powerdown");

    property p_epp;
        @(posedge clk) disable iff (!rst_n)
        parport_auto_pd_enable && !epp_config_enable |=> epp_powered_down;
    endproperty
    a_epp: assert property (p_epp) else $error("epp not powered down");
endmodule : apm_manager
`default_nettype wire

// ### test/apm_host_model.sv
/*
 * Host bus model: one-cycle read or write strobes with address and data.
 * Assumes the bench owns clk and checks every answer itself.
 */
`default_nettype none
module apm_host_model
    import apm_pkg::*;
(
    input wire logic clk,
    output apm_pkg::apm_host_req_type host_req
);
    timeunit 1ns;
    timeprecision 100ps;
    initial host_req = '0;
    // released bus shows inverted address and data
    task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk) host_req <= '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge clk) host_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : access
endmodule : apm_host_model
`default_nettype wire

// ### test/apm_manager_tb.sv
/*
 * Bench for the powerdown manager: host accesses and level stimulus.
 * Assumes apm_pkg and the host model are compiled first.
 */
`default_nettype none
module apm_manager_tb
    import apm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    apm_host_req_type host_req;
    apm_fdc_status_type fdc_status;
    apm_drive_core_type drive_core;
    apm_pin_type motor0_on_n, drive0_select_n, write_stream_n, write_gate_n;
    logic [7:0] host_rdata, drive_output_control, rate_select, rate_config_control;
    logic [2:0] ecr_mode;
    logic [1:0] density_sel, holding_empty, shift_empty, transmit_holding_write, rx_fifo_empty;
    logic [1:0] rx_wait_start, serial_receive_in, ring_indicator, tx_powered_down;
    logic [1:0] rx_powered_down, ring_indicator_level;
    logic clk, reset_n, supply_good_internal, host_ack, fifo_read_strobe, fifo_write_strobe;
    logic fdc_powered_down, fdc_access_awake, fdc_wake, head_direction_n, head_step_n;
    logic head_select_n, interrupt_request_out, dma_request_out, pll_powerdown_bit;
    logic event_power_bit, pll_powered, pll_reserved, floppy_auto_pd_enable;
    logic parport_auto_pd_enable, serial1_auto_pd_enable, serial2_auto_pd_enable;
    logic epp_config_enable, ecp_config_enable, epp_powered_down, ecp_powered_down;
    logic core_interrupt_request, core_dma_request, wake_event_out_n, hit;
    int err_count = 0, check_count = 0, cyc = 0;
    apm_manager #(.AUTO_PD_COUNT(20)) i_apm_manager (.*);
    apm_host_model i_apm_host_model (.clk(clk), .host_req(host_req));
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        i_apm_host_model.access(1'b1, a, d);
        #1;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        i_apm_host_model.access(1'b0, a, 8'h00);
        #1 chk(host_rdata, e);
    endtask : rd
    task automatic par(input logic [4:0] cfg, input logic [1:0] e);
        @(posedge clk) {epp_config_enable, ecp_config_enable, ecr_mode} <= cfg;
        repeat (2) @(posedge clk);
        #1 chk({epp_powered_down, ecp_powered_down}, e);
    endtask : par
    task automatic nap(input logic e);
        repeat (30) @(posedge clk);
        #1 chk(fdc_powered_down, e);
    endtask : nap
    initial begin
        {clk, reset_n, supply_good_internal, pll_powerdown_bit, event_power_bit} = '0;
        {floppy_auto_pd_enable, parport_auto_pd_enable, serial1_auto_pd_enable} = '0;
        {serial2_auto_pd_enable, epp_config_enable, ecp_config_enable, ecr_mode} = '0;
        {holding_empty, shift_empty, transmit_holding_write, rx_fifo_empty} = '0;
        {rx_wait_start, ring_indicator, drive_core} = '0;
        serial_receive_in = 2'b11;
        {core_interrupt_request, core_dma_request} = 2'b11;
        fdc_status = {8'h5A, 8'h3C, 8'h80, 8'h81, 8'h77, 1'b0, 1'b1};
        repeat (2) @(posedge clk);
        @(posedge clk) reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        i_apm_host_model.access(1'b0, OFS_STATUS_A, 8'h00);
        #1 chk(host_ack, 1'b0);
        @(posedge clk) ring_indicator <= 2'b10;
        repeat (4) @(posedge clk);
        #1 chk(wake_event_out_n, 1'b0);
        @(posedge clk) supply_good_internal <= 1'b1;
        repeat (4) @(posedge clk);
        rd(OFS_STATUS_A, 8'h5A);
        chk({host_ack, interrupt_request_out, wake_event_out_n}, 3'b111);
        $display("test host gating done");
        @(posedge clk) floppy_auto_pd_enable <= 1'b1;
        nap(1'b1);
        chk({interrupt_request_out, dma_request_out, fdc_access_awake}, 3'b000);
        chk({motor0_on_n.oe_n, write_gate_n.oe_n, head_step_n}, 3'b110);
        wr(OFS_DRIVE_OUT, 8'h04);
        rd(OFS_DRIVE_OUT, 8'h04);
        rd(OFS_INPUT_CFG, 8'h81);
        wr(OFS_INPUT_CFG, 8'h02);
        rd(OFS_STATUS_A, 8'h5A);
        chk(rate_config_control, 8'h02);
        chk(fdc_powered_down, 1'b1);
        rd(OFS_RATE_MAIN, 8'h80);
        chk(fdc_powered_down, 1'b0);
        nap(1'b1);
        wr(OFS_DRIVE_OUT, 8'h14);
        chk(fdc_powered_down, 1'b0);
        wr(OFS_DRIVE_OUT, 8'h04);
        wr(OFS_RATE_MAIN, 8'h40);
        chk(fdc_powered_down, 1'b1);
        rd(OFS_DATA, 8'h77);
        chk(fdc_powered_down, 1'b0);
        chk(rate_select, 8'h00);
        nap(1'b1);
        wr(OFS_RATE_MAIN, 8'h80);
        chk(fdc_powered_down, 1'b0);
        $display("test floppy done");
        for (int i = 0; i < 8; i++) begin
            @(posedge clk) {pll_powerdown_bit, event_power_bit, supply_good_internal} <= 3'(i);
            repeat (5) @(posedge clk);
            #1 chk({pll_powered, pll_reserved}, {i == 1, i < 4 && i != 1});
        end
        $display("test pll done");
        @(posedge clk) {serial1_auto_pd_enable, holding_empty, shift_empty} <= 5'h1F;
        {rx_fifo_empty, rx_wait_start} <= 4'hF;
        repeat (3) @(posedge clk);
        #1 chk({tx_powered_down, rx_powered_down}, 4'h5);
        @(posedge clk) transmit_holding_write <= 2'b01;
        @(posedge clk) transmit_holding_write <= 2'b00;
        #1 chk(tx_powered_down, 2'b00);
        @(posedge clk) {serial_receive_in, ring_indicator} <= 4'h9;
        hit = 1'b0;
        repeat (6) begin
            @(posedge clk);
            #1 hit = hit | (rx_powered_down[0] === 1'b0);
        end
        chk({hit, ring_indicator_level}, 3'h5);
        $display("test serial done");
        chk({epp_powered_down, ecp_powered_down}, 2'b00);
        @(posedge clk) parport_auto_pd_enable <= 1'b1;
        par({2'b10, ECR_SPP}, 2'b01);
        par({2'b11, ECR_EPP}, 2'b01);
        par({2'b11, ECR_SPP}, 2'b11);
        par({2'b01, 3'h3}, 2'b10);
        $display("test parallel done");
        report_and_stop();
    end
endmodule : apm_manager_tb
`default_nettype wire
